// file: verilog/ipg3_pkg.sv
// Package for the interrupt priority group 3 register block
package ipg3_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] REG_PRIORITY_OFS = 4'h0;
  localparam logic [3:0] REG_LEVELS_OFS = 4'h1;
  localparam logic [3:0] REG_GRANT_OFS = 4'h2;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int DMA_LSB = 8;
  localparam int ADC_LSB = 4;
  localparam int TX_LSB = 0;
  localparam int FIELD_W = 3;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [15:0] PRIO_WRITE_MASK = 16'h0777;
  localparam logic [15:0] PRIO_RESET_WORD = 16'h0444;
  localparam int NUM_SRC = 3;

  // ----------------------------------------
  // Bus carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ipg3_req_t;

  typedef logic [2:0] ipg3_level_t;

endpackage

// file: verilog/ipg3_priority.sv
// Priority register for DMA channel 1, analog converter and serial transmit interrupts
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module ipg3_priority (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire ipg3_pkg::ipg3_req_t busReq,
  output logic [15:0] rdData,
  // Pending interrupt requests: bit 2 DMA, bit 1 converter, bit 0 serial transmit
  input wire logic [2:0] srcPending,
  // Priority levels and arbitration result
  output logic [2:0] dmaChDonePriority,
  output logic [2:0] adcDonePriority,
  output logic [2:0] serialTxPriority,
  output logic grantValid,
  output logic [1:0] grantId,
  output logic [2:0] grantLevel
);

  // ----------------------------------------
  // Priority fields
  // ----------------------------------------
  logic [15:0] prioWord_r;
  logic [15:0] prioWord_nxt;
  logic wrPrio;

  assign wrPrio = busReq.wr && (busReq.addr == ipg3_pkg::REG_PRIORITY_OFS);

  // Masking on write keeps the unimplemented bits constant zero
  always_comb begin
    prioWord_nxt = prioWord_r;
    if (wrPrio) begin
      prioWord_nxt = busReq.wdata & ipg3_pkg::PRIO_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prioWord_r <= ipg3_pkg::PRIO_RESET_WORD;
    end else begin
      prioWord_r <= prioWord_nxt;
    end
  end

  // ----------------------------------------
  // Level outputs
  // ----------------------------------------
  logic [2:0] level [ipg3_pkg::NUM_SRC];

  assign level[2] = prioWord_r[ipg3_pkg::DMA_LSB +: ipg3_pkg::FIELD_W];
  assign level[1] = prioWord_r[ipg3_pkg::ADC_LSB +: ipg3_pkg::FIELD_W];
  assign level[0] = prioWord_r[ipg3_pkg::TX_LSB +: ipg3_pkg::FIELD_W];

  // Registered copies so that outputs come straight from flip-flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dmaChDonePriority <= ipg3_pkg::PRIO_RESET;
      adcDonePriority <= ipg3_pkg::PRIO_RESET;
      serialTxPriority <= ipg3_pkg::PRIO_RESET;
    end else begin
      dmaChDonePriority <= prioWord_nxt[ipg3_pkg::DMA_LSB +: ipg3_pkg::FIELD_W];
      adcDonePriority <= prioWord_nxt[ipg3_pkg::ADC_LSB +: ipg3_pkg::FIELD_W];
      serialTxPriority <= prioWord_nxt[ipg3_pkg::TX_LSB +: ipg3_pkg::FIELD_W];
    end
  end

  // ----------------------------------------
  // Arbitration among the three sources
  // ----------------------------------------
  // Ties go to the higher source index (DMA first), a fixed natural order
  logic anyWin;
  logic [1:0] winId;
  logic [2:0] winLevel;

  always_comb begin
    anyWin = 1'b0;
    winId = 2'h0;
    winLevel = ipg3_pkg::PRIO_OFF;
    for (int i = 0; i < ipg3_pkg::NUM_SRC; i++) begin
      if (srcPending[i] && (level[i] != ipg3_pkg::PRIO_OFF) && (level[i] >= winLevel)) begin
        anyWin = 1'b1;
        winId = 2'(i);
        winLevel = level[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      grantValid <= 1'b0;
      grantId <= 2'h0;
      grantLevel <= ipg3_pkg::PRIO_OFF;
    end else begin
      grantValid <= anyWin;
      grantId <= winId;
      grantLevel <= winLevel;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped offsets read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData <= 16'h0000;
    end else if (busReq.rd) begin
      case (busReq.addr)
        ipg3_pkg::REG_PRIORITY_OFS: rdData <= prioWord_r & ipg3_pkg::PRIO_WRITE_MASK;
        ipg3_pkg::REG_LEVELS_OFS: rdData <= {13'h0, srcPending};
        ipg3_pkg::REG_GRANT_OFS: rdData <= {10'h0, grantValid, grantId, grantLevel};
        default: rdData <= 16'h0000;
      endcase
    end else begin
      rdData <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// file: test/ipg3_priority_props.sv
// Port checks for the priority register
`timescale 1ns/10ps
`default_nettype none
module ipg3_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire ipg3_pkg::ipg3_req_t busReq,
  input wire logic [15:0] rdData,
  input wire logic [2:0] srcPending,
  input wire logic [2:0] dmaChDonePriority,
  input wire logic [2:0] adcDonePriority,
  input wire logic [2:0] serialTxPriority,
  input wire logic grantValid,
  input wire logic [1:0] grantId,
  input wire logic [2:0] grantLevel
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence wrReg;
    busReq.wr && busReq.addr == 4'h0;
  endsequence
  sequence rdReg;
    busReq.rd && busReq.addr == 4'h0;
  endsequence
  dma_field_a: assert property (wrReg |=> dmaChDonePriority == $past(busReq.wdata[10:8]))
    else $error("dma field");
  adc_field_a: assert property (wrReg |=> adcDonePriority == $past(busReq.wdata[6:4]))
    else $error("adc field");
  tx_field_a: assert property (wrReg |=> serialTxPriority == $past(busReq.wdata[2:0]))
    else $error("tx field");
  // Read word is built from the fields seen at the read edge
  read_zeros_a: assert property (rdReg |=> rdData == {5'h0, $past(dmaChDonePriority), 1'h0,
    $past(adcDonePriority), 1'h0, $past(serialTxPriority)}) else $error("read word");
  grant_level_a: assert property (srcPending == 3'h4 && dmaChDonePriority != 3'h0
    |=> grantValid && grantId == 2'h2 && grantLevel == $past(dmaChDonePriority)) else $error("grant");
  off_source_a: assert property (srcPending == 3'h4 && dmaChDonePriority == 3'h0 |=> !grantValid)
    else $error("disabled granted");
  reset_value_a: assert property ($fell(reset) |-> {dmaChDonePriority, adcDonePriority, serialTxPriority}
    == 9'h124) else $error("reset value");
endmodule
bind ipg3_priority ipg3_props chk_i (.clk(clk), .reset(reset), .busReq(busReq), .rdData(rdData),
  .srcPending(srcPending), .dmaChDonePriority(dmaChDonePriority), .adcDonePriority(adcDonePriority),
  .serialTxPriority(serialTxPriority), .grantValid(grantValid), .grantId(grantId), .grantLevel(grantLevel));
`default_nettype wire

// file: test/test_ipg3_priority.sv
// Self-checking bench for the priority register
`timescale 1ns/10ps
`default_nettype none
module test_ipg3_priority;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ipg3_pkg::ipg3_req_t busReq = '0;
  logic [2:0] srcPending = 3'h0;
  logic [15:0] rdData;
  logic [2:0] dmaP, adcP, txP, gLvl;
  logic gValid;
  logic [1:0] gId;
  int fail_count = 0;
  int cmp_count = 0;
  ipg3_priority dut (.clk(clk), .reset(reset), .busReq(busReq), .rdData(rdData), .srcPending(srcPending),
    .dmaChDonePriority(dmaP), .adcDonePriority(adcP), .serialTxPriority(txP), .grantValid(gValid),
    .grantId(gId), .grantLevel(gLvl));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk) busReq <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk) busReq.rd <= 1'b0;
    #1 chk(rdData, exp);
  endtask
  // Grant outputs lag pending inputs by one edge
  task automatic grant(input logic [2:0] p, input logic [15:0] exp);
    @(posedge clk) srcPending <= p;
    repeat (2) @(posedge clk);
    #1 chk({10'h0, gValid, gId, gLvl}, exp);
  endtask
  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(4'h0, 16'h0444);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h0777);
    @(posedge clk) #1 chk(rdData, 16'h0000);
    rd(4'h5, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, {5'h1f, 3'(c), 1'h1, 3'(7 - c), 1'h1, 3'(c)});
      #1 chk({7'h0, dmaP, adcP, txP}, {7'h0, 3'(c), 3'(7 - c), 3'(c)});
    end
    wr(4'h0, 16'h0053);
    grant(3'h7, 16'h002d);
    grant(3'h4, 16'h0000);
    rd(4'h1, 16'h0004);
    rd(4'h2, 16'h0000);
    wr(4'h0, 16'h0753);
    grant(3'h4, 16'h0037);
    rd(4'h2, 16'h0037);
    wr(4'h3, 16'h0111);
    rd(4'h0, 16'h0753);
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    rd(4'h0, 16'h0444);
    grant(3'h3, 16'h002c);
    final_report();
  end
endmodule
`default_nettype wire
